// ==== hw/uctd_params.svh ====
/*
 charger detection constants: codes, clock rate, timing in microseconds.
 assumes a 125 MHz system clock.
*/
`ifndef UCTD_PARAMS_SVH
`define UCTD_PARAMS_SVH
`define UCTD_CLK_MHZ 125
`define UCTD_TICK_US 1
`define UCTD_TICK_CYC (`UCTD_CLK_MHZ * `UCTD_TICK_US)
`define UCTD_DCD_US 300
`define UCTD_PRIM_US 40
`define UCTD_SEC_US 40
`define UCTD_CT_NONE 2'h0
`define UCTD_CT_SDP 2'h1
`define UCTD_CT_CDP 2'h2
`define UCTD_CT_DCP 2'h3
`define UCTD_PT_UNKNOWN 3'h0
`define UCTD_PT_VEND_A2A 3'h1
`define UCTD_PT_GEN_500 3'h2
`define UCTD_PT_VEND_B1A 3'h3
`define UCTD_PT_VEND_B2A 3'h4
`define UCTD_PT_VEND_B12W 3'h5
`define UCTD_LVL_LOW 3'h0
`define UCTD_LVL_L1 3'h1
`define UCTD_LVL_L2 3'h2
`define UCTD_LVL_L3 3'h3
`define UCTD_LVL_HIGH 3'h4
`endif

// ==== hw/uctd_pkg.sv ====
/*
 types of the charger detection block.
 assumes uctd_params.svh constants.
*/
package uctd_pkg;
    typedef enum logic [5:0] {
        UCTD_IDLE = 6'h01,
        UCTD_DCD = 6'h02,
        UCTD_PRIM = 6'h04,
        UCTD_SEC = 6'h08,
        UCTD_PROP = 6'h10,
        UCTD_DONE = 6'h20
    } uctd_state_t;
endpackage : uctd_pkg

// ==== hw/uctd_tick_if.sv ====
/*
 interface carrying the microsecond tick between divider and detector.
 assumes one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface uctd_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface : uctd_tick_if
`default_nettype wire

// ==== hw/uctd_tick_div.sv ====
/*
 divider producing a one-cycle enable every microsecond.
 assumes a synchronous single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uctd_params.svh"
module uctd_tick_div import uctd_pkg::*; #(
    parameter int DIV = `UCTD_TICK_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // tick out
    uctd_tick_if.src tk
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } uctd_div_t;
    uctd_div_t st_ff;
    uctd_div_t nxt_st;
    // count down and pulse on wrap
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt == 8'h00) begin
            nxt_st.cnt = 8'(DIV - 1);
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign tk.tick = st_ff.tick;
endmodule : uctd_tick_div
`default_nettype wire

// ==== hw/uctd_detect.sv ====
/*
 charger type detection: bc1.2 sequence, proprietary level table,
 charger enable, debug accessory and interrupt open-drain pins.
 assumes comparator inputs are synchronous digital levels from the analog front end.
*/
// Overview of operation
// R1 - interrupt pin is active-low open drain, released high only by pullup
// R2 - charger enable pin is active-low open drain with external pullup
// R3 - debug accessory pin pulls low whenever 80k sensed on either sideband pin
// R4 - after secondary detection finds DCP, D+ source voltage is switched off
// R5 - state machine follows BC1.2 and classifies SDP, CDP or DCP
// R6 - also recognise generic 500mA adapter and two vendor adapter families
// R7 - proprietary hits still report an SDP, CDP or DCP type
// R8 - shorted, biased D+/D- adapter reports as DCP plus its proprietary code
// R9 - running status of detection visible as a dedicated status bit
// R10 - type field codes: 00 none, 01 SDP, 10 CDP, 11 DCP
// R11 - running indication held from detection start until machine completes
// R12 - three-bit proprietary field, 0 unknown, 1 to 5 specific variants
// R13 - after detection the enable pin follows type and proprietary result
// R14 - type fields hold after completion until detach or a new run
`timescale 1ns/1ps
`default_nettype none
`include "uctd_params.svh"
module uctd_detect import uctd_pkg::*; #(
    parameter int DCD_US = `UCTD_DCD_US,
    parameter int PRIM_US = `UCTD_PRIM_US,
    parameter int SEC_US = `UCTD_SEC_US
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // attach and policy
    input wire logic i_vbus_valid,
    input wire logic i_not_usb_compliant,
    // analog comparators
    input wire logic i_dm_above_vdat,
    input wire logic i_dp_above_vdat,
    input wire logic i_dcd_contact,
    input wire logic [2:0] i_dp_level,
    input wire logic [2:0] i_dm_level,
    input wire logic i_sbu1_80k,
    input wire logic i_sbu2_80k,
    // analog controls
    output logic o_dplus_source_voltage,
    output logic o_dminus_source_voltage,
    // status
    output logic [1:0] o_charger_type_code,
    output logic [2:0] o_proprietary_type_code,
    output logic o_detection_running_flag,
    output logic o_detect_event,
    // open-drain pins
    output logic o_charger_en_n_out,
    output logic o_charger_en_n_oe,
    output logic o_debug_accessory_n_out,
    output logic o_debug_accessory_n_oe,
    output logic o_int_n_out,
    output logic o_int_n_oe
);
    localparam int DCD_CNT = DCD_US / `UCTD_TICK_US;
    localparam int PRIM_CNT = PRIM_US / `UCTD_TICK_US;
    localparam int SEC_CNT = SEC_US / `UCTD_TICK_US;

    typedef struct packed {
        uctd_state_t state;
        logic [9:0] tmr;
        logic [1:0] ctype;
        logic [2:0] ptype;
        logic dp_src;
        logic dm_src;
        logic running;
        logic done;
        logic event_p;
        logic int_pend;
        logic vbus_d;
        logic dbg;
        logic ce_low;
    } uctd_st_t;

    uctd_st_t st_ff;
    uctd_st_t nxt_st;
    uctd_tick_if tk ();

    uctd_tick_div u_div (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .tk(tk)
    );

    // proprietary lookup on quantised D+/D- levels
    function automatic logic [2:0] uctd_prop(input logic [2:0] dp, input logic [2:0] dm);
        logic [2:0] r;
        r = `UCTD_PT_UNKNOWN;
        if (dp == `UCTD_LVL_L1 && dm == `UCTD_LVL_L1) r = `UCTD_PT_VEND_A2A;
        if (dp == `UCTD_LVL_L2 && dm == `UCTD_LVL_L2) r = `UCTD_PT_GEN_500;
        if (dp == `UCTD_LVL_L2 && dm == `UCTD_LVL_L3) r = `UCTD_PT_VEND_B1A;
        if (dp == `UCTD_LVL_L3 && dm == `UCTD_LVL_L2) r = `UCTD_PT_VEND_B2A;
        if (dp == `UCTD_LVL_L3 && dm == `UCTD_LVL_L3) r = `UCTD_PT_VEND_B12W;
        return r;
    endfunction : uctd_prop

    // bc1.2 type that each proprietary adapter is also reported as
    function automatic logic [1:0] uctd_prop_base(input logic [2:0] p, input logic [1:0] bc);
        logic [1:0] r;
        case (p)
            `UCTD_PT_VEND_A2A: r = `UCTD_CT_DCP;
            `UCTD_PT_GEN_500: r = `UCTD_CT_SDP;
            `UCTD_PT_VEND_B1A: r = `UCTD_CT_CDP;
            `UCTD_PT_VEND_B2A: r = `UCTD_CT_SDP;
            `UCTD_PT_VEND_B12W: r = `UCTD_CT_DCP;
            default: r = bc;
        endcase
        return r;
    endfunction : uctd_prop_base

    // enable pin policy from final result
    function automatic logic uctd_ce(input logic [1:0] c, input logic [2:0] p, input logic nc);
        logic r;
        r = 1'b0;
        if (p != `UCTD_PT_UNKNOWN) r = 1'b1;
        else if (c == `UCTD_CT_DCP || c == `UCTD_CT_CDP) r = 1'b1;
        else if (c == `UCTD_CT_SDP) r = nc;
        return r;
    endfunction : uctd_ce

    // detection sequencer
    always_comb begin
        nxt_st = st_ff;
        nxt_st.event_p = 1'b0;
        nxt_st.vbus_d = i_vbus_valid;
        nxt_st.dbg = i_sbu1_80k | i_sbu2_80k; // R3
        if (tk.tick && st_ff.tmr != 10'h000) begin
            nxt_st.tmr = st_ff.tmr - 10'h001;
        end
        case (st_ff.state)
            UCTD_IDLE: begin
                if (i_vbus_valid && !st_ff.vbus_d) begin
                    nxt_st.state = UCTD_DCD;
                    nxt_st.tmr = 10'(DCD_CNT);
                    nxt_st.running = 1'b1; // R11
                    nxt_st.done = 1'b0;
                    nxt_st.int_pend = 1'b1; // R1
                end
            end
            UCTD_DCD: begin
                if (i_dcd_contact || st_ff.tmr == 10'h000) begin
                    nxt_st.state = UCTD_PRIM;
                    nxt_st.tmr = 10'(PRIM_CNT);
                    nxt_st.dp_src = 1'b1;
                end
            end
            UCTD_PRIM: begin
                if (st_ff.tmr == 10'h000) begin
                    nxt_st.dp_src = 1'b0;
                    if (i_dm_above_vdat) begin // R5
                        nxt_st.state = UCTD_SEC;
                        nxt_st.tmr = 10'(SEC_CNT);
                        nxt_st.dm_src = 1'b1;
                    end else begin
                        nxt_st.ctype = `UCTD_CT_SDP; // R10
                        nxt_st.state = UCTD_PROP;
                    end
                end
            end
            UCTD_SEC: begin
                if (st_ff.tmr == 10'h000) begin
                    nxt_st.dm_src = 1'b0;
                    nxt_st.dp_src = 1'b0; // R4
                    nxt_st.ctype = i_dp_above_vdat ? `UCTD_CT_DCP : `UCTD_CT_CDP; // R5
                    nxt_st.state = UCTD_PROP;
                end
            end
            UCTD_PROP: begin
                nxt_st.ptype = uctd_prop(i_dp_level, i_dm_level); // R6 R12
                nxt_st.ctype = uctd_prop_base(nxt_st.ptype, st_ff.ctype); // R7 R8
                nxt_st.ce_low = uctd_ce(nxt_st.ctype, nxt_st.ptype, i_not_usb_compliant); // R13
                nxt_st.running = 1'b0; // R11
                nxt_st.done = 1'b1;
                nxt_st.event_p = 1'b1;
                nxt_st.int_pend = 1'b1;
                nxt_st.state = UCTD_DONE;
            end
            UCTD_DONE: begin
                nxt_st.int_pend = 1'b0;
                // R14
            end
            default: begin
                nxt_st.state = UCTD_IDLE;
            end
        endcase
        // detach clears result and returns to idle
        if (!i_vbus_valid && st_ff.state != UCTD_IDLE) begin
            nxt_st.state = UCTD_IDLE;
            nxt_st.ctype = `UCTD_CT_NONE; // R14
            nxt_st.ptype = `UCTD_PT_UNKNOWN;
            nxt_st.dp_src = 1'b0;
            nxt_st.dm_src = 1'b0;
            nxt_st.running = 1'b0;
            nxt_st.done = 1'b0;
            nxt_st.ce_low = 1'b0;
            nxt_st.event_p = 1'b1;
            nxt_st.int_pend = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= '{state: UCTD_IDLE, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs and open-drain drives
    assign o_dplus_source_voltage = st_ff.dp_src;
    assign o_dminus_source_voltage = st_ff.dm_src;
    assign o_charger_type_code = st_ff.ctype;
    assign o_proprietary_type_code = st_ff.ptype;
    assign o_detection_running_flag = st_ff.running; // R9
    assign o_detect_event = st_ff.event_p;
    assign o_charger_en_n_out = 1'b0; // R2
    assign o_charger_en_n_oe = st_ff.ce_low; // R2
    assign o_debug_accessory_n_out = 1'b0;
    assign o_debug_accessory_n_oe = st_ff.dbg; // R3
    assign o_int_n_out = 1'b0; // R1
    assign o_int_n_oe = st_ff.int_pend | st_ff.event_p; // R1

    // assertions
    property p_od_pins;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        !o_int_n_out && !o_charger_en_n_out && !o_debug_accessory_n_out;
    endproperty
    a_od_pins: assert property (p_od_pins) else $error("open drain drives high"); // R1
    property p_dbg;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_sbu1_80k || i_sbu2_80k) |=> o_debug_accessory_n_oe;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug pin not pulled"); // R3
    property p_dcp_src_off;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (o_charger_type_code == `UCTD_CT_DCP && !o_detection_running_flag)
            |-> !o_dplus_source_voltage;
    endproperty
    a_dcp_src_off: assert property (p_dcp_src_off) else $error("dp source on after dcp"); // R4
    property p_sdp;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.state == UCTD_PRIM && st_ff.tmr == 10'h000 && !i_dm_above_vdat && i_vbus_valid)
            |=> o_charger_type_code == `UCTD_CT_SDP;
    endproperty
    a_sdp: assert property (p_sdp) else $error("sdp not reported"); // R5
    property p_prop_base;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.done && o_proprietary_type_code != `UCTD_PT_UNKNOWN)
            |-> o_charger_type_code != `UCTD_CT_NONE;
    endproperty
    a_prop_base: assert property (p_prop_base) else $error("proprietary without type"); // R7
    property p_a2a_dcp;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.done && o_proprietary_type_code == `UCTD_PT_VEND_A2A)
            |-> o_charger_type_code == `UCTD_CT_DCP;
    endproperty
    a_a2a_dcp: assert property (p_a2a_dcp) else $error("shorted adapter not dcp"); // R8
    property p_run;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.state inside {UCTD_DCD, UCTD_PRIM, UCTD_SEC}) |-> o_detection_running_flag;
    endproperty
    a_run: assert property (p_run) else $error("running flag dropped"); // R11
    property p_ptype_range;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        o_proprietary_type_code <= `UCTD_PT_VEND_B12W;
    endproperty
    a_ptype_range: assert property (p_ptype_range) else $error("bad proprietary code"); // R12
    property p_ce;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.done && o_charger_type_code == `UCTD_CT_DCP) |-> o_charger_en_n_oe;
    endproperty
    a_ce: assert property (p_ce) else $error("enable not asserted for dcp"); // R13
    property p_hold;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.state == UCTD_DONE && i_vbus_valid) |=> $stable(o_charger_type_code);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed while attached"); // R14
endmodule : uctd_detect
`default_nettype wire

// ==== tb/uctd_charger_model.sv ====
/*
 behavioural charger or host port on the connector data lines.
 assumes the detector's source-voltage controls and comparator inputs are digital levels.
*/
`timescale 1ns/1ps
`default_nettype none
module uctd_charger_model (
    // scenario setup
    input wire logic i_attached,
    input wire logic [1:0] i_port_kind,
    input wire logic [2:0] i_dp_band,
    input wire logic [2:0] i_dm_band,
    // detector drive
    input wire logic i_dp_src,
    input wire logic i_dm_src,
    // comparator view
    output logic o_dm_above_vdat,
    output logic o_dp_above_vdat,
    output logic o_dcd_contact,
    output logic [2:0] o_dp_level,
    output logic [2:0] o_dm_level
);
    // cdp and dcp echo the d+ source on d-, only a dcp echoes the d- source on d+
    always_comb begin
        o_dm_above_vdat = i_attached && i_dp_src && (i_port_kind >= 2'h2);
        o_dp_above_vdat = i_attached && i_dm_src && (i_port_kind == 2'h3);
        o_dcd_contact = i_attached;
        o_dp_level = i_attached ? i_dp_band : 3'h0; // floating lines read low
        o_dm_level = i_attached ? i_dm_band : 3'h0;
    end
endmodule : uctd_charger_model
`default_nettype wire

// ==== tb/usb_charger_type_detection_test.sv ====
/*
 self-checking bench for the charger type detector.
 assumes the detector as top, short timing parameters and a behavioural charger.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uctd_params.svh"
module usb_charger_type_detection_test;
    localparam int LIMIT = 3000;
    // stimulus and observed signals
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic vbus = 1'b0;
    logic notc = 1'b0;
    logic sbu1 = 1'b0;
    logic sbu2 = 1'b0;
    logic attached = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [2:0] dpb = 3'h0;
    logic [2:0] dmb = 3'h0;
    logic dm_hi, dp_hi, contact, dp_src, dm_src, running, event_p;
    logic ce_out, ce_oe, db_out, db_oe, int_out, int_oe;
    logic [2:0] dp_lvl, dm_lvl, pt;
    logic [1:0] ct;
    int n_errors = 0;
    int tests_run = 0;
    // pin levels with external pullups
    wire ce_pin = ce_oe ? ce_out : 1'b1;
    wire db_pin = db_oe ? db_out : 1'b1;
    wire int_pin = int_oe ? int_out : 1'b1;

    // 125 MHz clock
    always #4 i_sys_clk = ~i_sys_clk;

    uctd_detect #(.DCD_US(3), .PRIM_US(3), .SEC_US(3)) u_dut (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_vbus_valid(vbus),
        .i_not_usb_compliant(notc), .i_dm_above_vdat(dm_hi), .i_dp_above_vdat(dp_hi),
        .i_dcd_contact(contact), .i_dp_level(dp_lvl), .i_dm_level(dm_lvl),
        .i_sbu1_80k(sbu1), .i_sbu2_80k(sbu2), .o_dplus_source_voltage(dp_src),
        .o_dminus_source_voltage(dm_src), .o_charger_type_code(ct),
        .o_proprietary_type_code(pt), .o_detection_running_flag(running),
        .o_detect_event(event_p), .o_charger_en_n_out(ce_out), .o_charger_en_n_oe(ce_oe),
        .o_debug_accessory_n_out(db_out), .o_debug_accessory_n_oe(db_oe),
        .o_int_n_out(int_out), .o_int_n_oe(int_oe)
    );

    uctd_charger_model u_port (
        .i_attached(attached), .i_port_kind(kind), .i_dp_band(dpb), .i_dm_band(dmb),
        .i_dp_src(dp_src), .i_dm_src(dm_src), .o_dm_above_vdat(dm_hi),
        .o_dp_above_vdat(dp_hi), .o_dcd_contact(contact), .o_dp_level(dp_lvl),
        .o_dm_level(dm_lvl)
    );

    // compare one value, count it, report a difference
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // print counts and verdict, then stop
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // present a port and raise or drop vbus with it
    task automatic set_port(input logic on, input logic [1:0] k, input logic [2:0] p,
                            input logic [2:0] m, input logic nc);
        @(posedge i_sys_clk);
        attached <= on;
        vbus <= on;
        kind <= k;
        dpb <= p;
        dmb <= m;
        notc <= nc;
    endtask : set_port

    // full detection: running held, result codes, pins, hold and detach
    task automatic run_case(input logic [1:0] k, input logic [2:0] p, input logic [2:0] m,
                            input logic nc, input logic [1:0] ect, input logic [2:0] ept,
                            input logic ce_exp);
        int n;
        logic dp_seen;
        logic dm_seen;
        set_port(1'b1, k, p, m, nc);
        repeat (3) @(negedge i_sys_clk);
        n = 0;
        dp_seen = 1'b0;
        dm_seen = 1'b0;
        while (event_p !== 1'b1 && n < LIMIT) begin
            check("running", 4'(running), 4'h1);
            check("int_run", 4'(int_pin), 4'h0);
            dp_seen = dp_seen | (dp_src === 1'b1);
            dm_seen = dm_seen | (dm_src === 1'b1);
            @(negedge i_sys_clk);
            n++;
        end
        if (n == LIMIT) begin
            n_errors++;
            finish_test();
        end
        check("running_done", 4'(running), 4'h0);
        check("dp_src_seen", 4'(dp_seen), 4'h1);
        check("dm_src_seen", 4'(dm_seen), 4'(k >= 2'h2));
        check("int_pin", 4'(int_pin), 4'h0);
        check("type", 4'(ct), 4'(ect));
        check("prop", 4'(pt), 4'(ept));
        repeat (2) @(negedge i_sys_clk);
        check("ce_pin", 4'(ce_pin), 4'(ce_exp));
        check("ce_out", 4'(ce_out), 4'h0);
        check("int_idle", 4'(int_pin), 4'h1);
        if (ect == `UCTD_CT_DCP) begin
            check("dp_src", 4'(dp_src), 4'h0);
        end
        // lines change after completion, result must not
        @(posedge i_sys_clk);
        kind <= 2'h0;
        dpb <= 3'h4;
        dmb <= 3'h4;
        repeat (20) @(negedge i_sys_clk);
        check("type_hold", 4'(ct), 4'(ect));
        check("prop_hold", 4'(pt), 4'(ept));
        set_port(1'b0, 2'h0, 3'h0, 3'h0, nc);
        n = 0;
        repeat (4) begin
            @(negedge i_sys_clk);
            n += int'(event_p === 1'b1);
        end
        check("detach_event", 4'(n), 4'h1);
        check("type_gone", 4'(ct), 4'(`UCTD_CT_NONE));
        check("prop_gone", 4'(pt), 4'(`UCTD_PT_UNKNOWN));
        check("ce_gone", 4'(ce_pin), 4'h1);
    endtask : run_case

    // detach in mid-run aborts and leaves no result
    task automatic abort_case();
        set_port(1'b1, 2'h3, 3'h0, 3'h0, 1'b0);
        repeat (300) @(negedge i_sys_clk);
        check("abort_running", 4'(running), 4'h1);
        set_port(1'b0, 2'h0, 3'h0, 3'h0, 1'b0);
        repeat (4) @(negedge i_sys_clk);
        check("abort_idle", 4'(running), 4'h0);
        check("abort_type", 4'(ct), 4'(`UCTD_CT_NONE));
    endtask : abort_case

    // every combination of the sideband resistor sensors
    task automatic sbu_case();
        for (int i = 0; i < 4; i++) begin
            @(posedge i_sys_clk);
            sbu1 <= i[0];
            sbu2 <= i[1];
            repeat (3) @(negedge i_sys_clk);
            check("db_pin", 4'(db_pin), (i == 0) ? 4'h1 : 4'h0);
            check("db_out", 4'(db_out), 4'h0);
        end
    endtask : sbu_case

    // main sequence
    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        @(negedge i_sys_clk);
        check("rst_type", 4'(ct), 4'h0);
        check("rst_int", 4'(int_pin), 4'h1);
        check("rst_ce", 4'(ce_pin), 4'h1);
        run_case(2'h1, 3'h0, 3'h0, 1'b0, `UCTD_CT_SDP, `UCTD_PT_UNKNOWN, 1'b1);
        run_case(2'h1, 3'h0, 3'h0, 1'b1, `UCTD_CT_SDP, `UCTD_PT_UNKNOWN, 1'b0);
        run_case(2'h2, 3'h0, 3'h0, 1'b0, `UCTD_CT_CDP, `UCTD_PT_UNKNOWN, 1'b0);
        run_case(2'h3, 3'h0, 3'h0, 1'b1, `UCTD_CT_DCP, `UCTD_PT_UNKNOWN, 1'b0);
        run_case(2'h3, 3'h1, 3'h1, 1'b0, `UCTD_CT_DCP, `UCTD_PT_VEND_A2A, 1'b0);
        run_case(2'h1, 3'h2, 3'h2, 1'b0, `UCTD_CT_SDP, `UCTD_PT_GEN_500, 1'b0);
        run_case(2'h2, 3'h2, 3'h3, 1'b0, `UCTD_CT_CDP, `UCTD_PT_VEND_B1A, 1'b0);
        run_case(2'h1, 3'h3, 3'h2, 1'b0, `UCTD_CT_SDP, `UCTD_PT_VEND_B2A, 1'b0);
        run_case(2'h3, 3'h3, 3'h3, 1'b0, `UCTD_CT_DCP, `UCTD_PT_VEND_B12W, 1'b0);
        abort_case();
        sbu_case();
        finish_test();
    end
endmodule : usb_charger_type_detection_test
`default_nettype wire
